/* File: src/tsl_map.svh */
`ifndef TSL_MAP_SVH
`define TSL_MAP_SVH

// register byte offsets (haddr[7:0])
`define TSL_OFS_CTRL 8'h00
`define TSL_OFS_SPD_LIM 8'h04
`define TSL_OFS_GAIN 8'h08
`define TSL_OFS_MOTOR_MAX 8'h0c
`define TSL_OFS_RATED 8'h10
`define TSL_OFS_STATUS 8'h14
`define TSL_OFS_IRQ_STAT 8'h18
`define TSL_OFS_IRQ_MASK 8'h1c
`define TSL_OFS_OFFSET 8'h20
`define TSL_OFS_OFS_CMD 8'h24

// control field positions
`define TSL_CTRL_SRC 0
`define TSL_CTRL_TQM 1
`define TSL_CTRL_MAN 2
// offset command bits
`define TSL_CMD_INC 0
`define TSL_CMD_DEC 1
// status bits and limit field
`define TSL_STAT_LIM 0
`define TSL_STAT_SRV 1
`define TSL_STAT_EFF_LSB 16
// interrupt bits
`define TSL_IRQ_ENTER 0
`define TSL_IRQ_LEAVE 1

// speed limit setting, min^-1
`define TSL_SPD_LIM_MAX 14'h2710
`define TSL_SPD_LIM_RST 14'h2710
// speed input gain, 0.01 V per rated speed
`define TSL_GAIN_MIN 12'h096
`define TSL_GAIN_MAX 12'hbb8
`define TSL_GAIN_RST 12'h258

`endif

/* File: src/tsl_pkg.sv */
package tsl_pkg;
  typedef enum logic {
    TSL_BUS_IDLE = 1'b0,
    TSL_BUS_DATA = 1'b1
  } tsl_bus_e;
  typedef logic [13:0] tsl_speed_t;
  typedef logic [11:0] tsl_gain_t;
endpackage

/* File: src/tsl_divider.sv */
`timescale 1ns/1ps
// restoring divider, one quotient bit per clock
module tsl_divider #(
  parameter int W = 30,
  parameter int DW = 12
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [W-1:0] i_num,
  input wire logic [DW-1:0] i_den,
  output logic [W-1:0] o_quot,
  output logic o_done
);
  logic [W-1:0] num_q;
  logic [W-1:0] num_l_q;
  logic [DW-1:0] den_q;
  logic [DW:0] rem_q;
  logic [DW:0] rem_sh;
  logic [7:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic ge;

  if (W < 2 || W > 200 || DW < 1) begin : g_bad_width
    $error("tsl_divider: unsupported width");
  end

  assign rem_sh = {rem_q[DW-1:0], num_q[W-1]};
  assign ge = rem_sh >= {1'b0, den_q};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      num_q <= '0;
      num_l_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (!busy_q) begin
      done_q <= 1'b0;
      if (i_start) begin
        num_q <= i_num;
        num_l_q <= i_num;
        den_q <= i_den;
        rem_q <= '0;
        cnt_q <= 8'(W);
        busy_q <= 1'b1;
      end
    end else begin
      rem_q <= ge ? rem_sh - {1'b0, den_q} : rem_sh;
      num_q <= {num_q[W-2:0], ge};
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign o_quot = num_q;
  assign o_done = done_q;

  a_div_exact: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_done |-> ((W+DW)'(o_quot) * (W+DW)'(den_q) <= (W+DW)'(num_l_q)) &&
      ((W+DW)'(o_quot) * (W+DW)'(den_q) + (W+DW)'(den_q) > (W+DW)'(num_l_q)))
    else $error("divider quotient wrong");
endmodule // tsl_divider

/* File: src/tsl_top.sv */
`timescale 1ns/1ps
`include "tsl_map.svh"

// Operation
// - source select 0 uses the internal speed-limit setting as limit.
// - source select 1 derives limit from analog speed input scaled by gain.
// - internal setting spans 0 to 10000 min^-1, resets 10000, acts immediately.
// - internal setting above motor maximum speed is replaced by motor maximum.
// - external mode limit is the smaller of analog limit and internal setting.
// - analog limit uses input magnitude; sign is ignored.
// - gain spans 150 to 3000 (0.01 V/rated speed), resets 600, acts immediately.
// - analog limit equals rated speed times voltage over gain times 0.01 V.
// - overspeed produces negative-feedback torque proportional to the excess.
// - status output is low while limiting applies, high otherwise.
// - status asserts when speed reaches the active limit, either source.
// - manual offset mode acts like auto offset, amount entered directly.
// - in manual mode with servo on, increment/decrement adjust the offset.
// - offset is retained and corrects the analog torque reference.
module tsl_top
  import tsl_pkg::*;
#(
  parameter tsl_speed_t MOTOR_MAX_RST = 14'h1388,
  parameter tsl_speed_t RATED_RST = 14'h0bb8,
  parameter int OFS_LIMIT = 127,
  parameter int KP_SHIFT = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic i_servo_on,
  input wire logic signed [15:0] i_motor_speed,
  input wire logic signed [15:0] i_vref,
  input wire logic signed [15:0] i_torque_ref,
  output logic signed [15:0] o_torque_cmd,
  output logic o_speed_limit_active_n,
  output logic o_irq
);
  if (OFS_LIMIT < 1 || OFS_LIMIT > 32767 || KP_SHIFT < 0 || KP_SHIFT > 3) begin : g_bad
    $error("tsl_top: unsupported parameter value");
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // ---------------- AHB-Lite slave ----------------
  tsl_bus_e bus_q;
  logic [7:0] addr_q;
  logic wr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic wr_en;

  // one wait state per transfer so a read never races the write before it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      bus_q <= TSL_BUS_IDLE;
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      unique case (bus_q)
        TSL_BUS_IDLE: begin
          if (i_hsel && i_htrans[1] && i_hready) begin
            addr_q <= i_haddr[7:0];
            wr_q <= i_hwrite;
            hready_q <= 1'b0;
            bus_q <= TSL_BUS_DATA;
          end
        end
        TSL_BUS_DATA: begin
          hready_q <= 1'b1;
          hrdata_q <= wr_q ? 32'h0000_0000 : rd_mux;
          bus_q <= TSL_BUS_IDLE;
        end
      endcase
    end
  end

  assign wr_en = (bus_q == TSL_BUS_DATA) && wr_q;
  assign o_hreadyout = hready_q;
  assign o_hrdata = hrdata_q;
  assign o_hresp = 1'b0;

  // ---------------- configuration registers ----------------
  logic src_q;
  logic tqm_q;
  logic man_q;
  tsl_speed_t spd_lim_q;
  tsl_gain_t gain_q;
  tsl_speed_t motor_max_q;
  tsl_speed_t rated_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic inc_q;
  logic dec_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      src_q <= 1'b0;
      tqm_q <= 1'b0;
      man_q <= 1'b0;
    end else if (wr_en && addr_q == `TSL_OFS_CTRL) begin
      src_q <= i_hwdata[`TSL_CTRL_SRC];
      tqm_q <= i_hwdata[`TSL_CTRL_TQM];
      man_q <= i_hwdata[`TSL_CTRL_MAN];
    end
  end

  // out-of-range writes clamp to the nearest legal value
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      spd_lim_q <= `TSL_SPD_LIM_RST;
    end else if (wr_en && addr_q == `TSL_OFS_SPD_LIM) begin
      spd_lim_q <= (i_hwdata > 32'(`TSL_SPD_LIM_MAX)) ? `TSL_SPD_LIM_MAX : i_hwdata[13:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gain_q <= `TSL_GAIN_RST;
    end else if (wr_en && addr_q == `TSL_OFS_GAIN) begin
      if (i_hwdata > 32'(`TSL_GAIN_MAX)) begin
        gain_q <= `TSL_GAIN_MAX;
      end else if (i_hwdata < 32'(`TSL_GAIN_MIN)) begin
        gain_q <= `TSL_GAIN_MIN;
      end else begin
        gain_q <= i_hwdata[11:0];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      motor_max_q <= MOTOR_MAX_RST;
      rated_q <= RATED_RST;
    end else if (wr_en && addr_q == `TSL_OFS_MOTOR_MAX) begin
      motor_max_q <= i_hwdata[13:0];
    end else if (wr_en && addr_q == `TSL_OFS_RATED) begin
      rated_q <= i_hwdata[13:0];
    end
  end

  a_spd_range: assert property (spd_lim_q <= `TSL_SPD_LIM_MAX)
    else $error("speed limit setting out of range");
  a_gain_range: assert property (gain_q >= `TSL_GAIN_MIN && gain_q <= `TSL_GAIN_MAX)
    else $error("gain setting out of range");

  // ---------------- servo-on pin synchroniser ----------------
  logic srv_s1_q;
  logic srv_s2_q;
  logic srv_s3_q;
  logic srv_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      srv_s1_q <= 1'b0;
      srv_s2_q <= 1'b0;
      srv_s3_q <= 1'b0;
      srv_q <= 1'b0;
    end else begin
      srv_s1_q <= i_servo_on;
      srv_s2_q <= srv_s1_q;
      srv_s3_q <= srv_s2_q;
      if (srv_s2_q == srv_s3_q) begin
        srv_q <= srv_s3_q;
      end
    end
  end

  // ---------------- external limit from analog reference ----------------
  logic [15:0] abs_vref;
  logic [29:0] ext_num;
  logic [29:0] quot;
  logic div_done;
  tsl_speed_t ext_lim_q;

  // magnitude only; -32768 maps to 32768 in the unsigned result
  assign abs_vref = i_vref[15] ? 16'(-i_vref) : i_vref;
  assign ext_num = 30'(rated_q) * 30'(abs_vref);

  // recomputes continuously, so gain and input changes land within two passes
  tsl_divider #(
    .W(30),
    .DW(12)
  ) u_div (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(1'b1),
    .i_num(ext_num),
    .i_den(gain_q),
    .o_quot(quot),
    .o_done(div_done)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ext_lim_q <= `TSL_SPD_LIM_RST;
    end else if (div_done) begin
      ext_lim_q <= (|quot[29:14]) ? 14'h3fff : quot[13:0];
    end
  end

  // ---------------- effective limit and status ----------------
  tsl_speed_t int_lim;
  tsl_speed_t eff_d;
  tsl_speed_t eff_lim_q;
  logic [15:0] abs_spd;
  logic lim_d;
  logic lim_q;
  logic lim_n_q;

  assign int_lim = (spd_lim_q > motor_max_q) ? motor_max_q : spd_lim_q;
  assign eff_d = (src_q && ext_lim_q < int_lim) ? ext_lim_q : int_lim;
  assign abs_spd = i_motor_speed[15] ? 16'(-i_motor_speed) : i_motor_speed;
  assign lim_d = tqm_q && ({2'b00, eff_lim_q} <= abs_spd);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      // start at the smaller reset limit so the motor clamp holds from the first cycle
      eff_lim_q <= (MOTOR_MAX_RST < `TSL_SPD_LIM_RST) ? MOTOR_MAX_RST : `TSL_SPD_LIM_RST;
      lim_q <= 1'b0;
      lim_n_q <= 1'b1;
    end else begin
      eff_lim_q <= eff_d;
      lim_q <= lim_d;
      lim_n_q <= ~lim_d;
    end
  end

  assign o_speed_limit_active_n = lim_n_q;

  a_int_select: assert property (!src_q |=> eff_lim_q == $past(int_lim))
    else $error("internal limit not selected");
  a_motor_clamp: assert property (eff_lim_q <= motor_max_q || $changed(motor_max_q))
    else $error("limit above motor maximum");
  a_ext_select: assert property (src_q && ext_lim_q < int_lim |=> eff_lim_q == $past(ext_lim_q))
    else $error("external limit not taken");
  a_flag_low: assert property (lim_d |=> !o_speed_limit_active_n ##0 lim_q)
    else $error("status not asserted at limit");
  a_not_torque: assert property (!tqm_q |=> o_speed_limit_active_n)
    else $error("status asserted outside torque mode");

  // ---------------- torque offset, manual entry ----------------
  logic signed [15:0] offset_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      inc_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      inc_q <= wr_en && addr_q == `TSL_OFS_OFS_CMD && i_hwdata[`TSL_CMD_INC];
      dec_q <= wr_en && addr_q == `TSL_OFS_OFS_CMD && i_hwdata[`TSL_CMD_DEC];
    end
  end

  // same offset store as the auto adjust would fill; entered by steps here
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      offset_q <= 16'sh0000;
    end else if (man_q && srv_q && inc_q && !dec_q) begin
      if (offset_q < 16'(OFS_LIMIT)) begin
        offset_q <= offset_q + 16'sh0001;
      end
    end else if (man_q && srv_q && dec_q && !inc_q) begin
      if (offset_q > -16'(OFS_LIMIT)) begin
        offset_q <= offset_q - 16'sh0001;
      end
    end
  end

  sequence s_step_up;
    man_q && srv_q && inc_q && !dec_q && offset_q < 16'(OFS_LIMIT);
  endsequence
  sequence s_idle_cmd;
    !inc_q && !dec_q;
  endsequence
  a_ofs_step: assert property (s_step_up |=> offset_q == $past(offset_q) + 16'sh0001)
    else $error("offset did not step up");
  a_ofs_hold: assert property (s_idle_cmd [*2] |-> $stable(offset_q))
    else $error("offset changed without command");

  // ---------------- torque command with speed feedback ----------------
  logic signed [19:0] base_w;
  logic signed [19:0] fb_w;
  logic signed [19:0] sum_w;
  logic [16:0] exc;
  logic over;
  logic signed [15:0] tq_q;

  assign base_w = 20'(i_torque_ref) + 20'(offset_q);
  assign exc = {1'b0, abs_spd} - {3'b000, eff_lim_q};
  assign over = tqm_q && ({2'b00, eff_lim_q} < abs_spd);
  assign fb_w = over ? ($signed(20'(exc)) <<< KP_SHIFT) : 20'sh00000;
  assign sum_w = i_motor_speed[15] ? base_w + fb_w : base_w - fb_w;

  // saturate rather than wrap; a wrap would flip the torque sign
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tq_q <= 16'sh0000;
    end else if (sum_w > 20'sh07fff) begin
      tq_q <= 16'sh7fff;
    end else if (sum_w < -20'sh08000) begin
      tq_q <= 16'sh8000;
    end else begin
      tq_q <= sum_w[15:0];
    end
  end

  assign o_torque_cmd = tq_q;

  a_fb_brake: assert property (over && !i_motor_speed[15] && base_w < 20'sh07fff &&
      base_w > -20'sh08000 |=> $signed(o_torque_cmd) < $past(base_w))
    else $error("no braking torque on overspeed");

  // ---------------- interrupts and readback ----------------
  logic [1:0] ev;
  logic [1:0] clr;
  logic irq_q;

  assign ev = {~lim_d & lim_q, lim_d & ~lim_q};
  assign clr = (wr_en && addr_q == `TSL_OFS_IRQ_STAT) ? i_hwdata[1:0] : 2'b00;

  // a new event beats a same-cycle clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
      if (wr_en && addr_q == `TSL_OFS_IRQ_MASK) begin
        irq_mask_q <= i_hwdata[1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign o_irq = irq_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      `TSL_OFS_CTRL: rd_mux = {29'h0, man_q, tqm_q, src_q};
      `TSL_OFS_SPD_LIM: rd_mux = {18'h0, spd_lim_q};
      `TSL_OFS_GAIN: rd_mux = {20'h0, gain_q};
      `TSL_OFS_MOTOR_MAX: rd_mux = {18'h0, motor_max_q};
      `TSL_OFS_RATED: rd_mux = {18'h0, rated_q};
      `TSL_OFS_STATUS: rd_mux = {2'b00, eff_lim_q, 14'h0, srv_q, lim_q};
      `TSL_OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
      `TSL_OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_q};
      `TSL_OFS_OFFSET: rd_mux = 32'(offset_q);
      default: rd_mux = 32'h0000_0000;
    endcase
  end
endmodule // tsl_top

/* File: bench/tsl_vref_host.sv */
`timescale 1ns/1ps
// host side of the analog speed reference, levels in 0.01 V
module tsl_vref_host (
  input wire logic i_core_clk,
  output logic signed [15:0] o_vref
);
  logic signed [15:0] level_q = 16'sh0000;
  // a slow host settles its output only after lag + 1 cycles
  task automatic put(input logic signed [15:0] level, input int lag);
    repeat (lag + 1) @(posedge i_core_clk);
    level_q <= level;
  endtask
  assign o_vref = level_q;
endmodule // tsl_vref_host

/* File: bench/tb_tsl_top.sv */
`timescale 1ns/1ps
`include "tsl_map.svh"
module tb_tsl_top
  import tsl_pkg::*;
;
  localparam logic [31:0] SRC = 32'h1 << `TSL_CTRL_SRC;
  localparam logic [31:0] TQM = 32'h1 << `TSL_CTRL_TQM;
  localparam logic [31:0] MAN = 32'h1 << `TSL_CTRL_MAN;
  localparam logic [31:0] EFF_M = 32'h3fff0000;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic servo_on = 1'b0;
  logic signed [15:0] speed = 16'sh0000;
  logic signed [15:0] tref = 16'sh0000;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic lim_n;
  logic [31:0] hrdata;
  logic signed [15:0] vref;
  logic signed [15:0] tcmd;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int vt[6] = '{0, 600, -600, 601, 300, 600};
  int gt[6] = '{600, 600, 600, 600, 150, 600};
  int et[6] = '{0, 3000, 3000, 3005, 6000, 3000};

  tsl_top #(.MOTOR_MAX_RST(14'h1388), .RATED_RST(14'h0bb8), .OFS_LIMIT(127), .KP_SHIFT(2)) dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_servo_on(servo_on), .i_motor_speed(speed), .i_vref(vref), .i_torque_ref(tref),
    .o_torque_cmd(tcmd), .o_speed_limit_active_n(lim_n), .o_irq(irq));
  tsl_vref_host host (.i_core_clk(i_core_clk), .o_vref(vref));

  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the run needs a few thousand cycles; far beyond that means a hung handshake
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge i_core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ofs};
    @(posedge i_core_clk);
    while (hreadyout !== 1'b1) @(posedge i_core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge i_core_clk);
    while (hreadyout !== 1'b1) @(posedge i_core_clk);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, ofs, wd, d);
  endtask

  task automatic rdm(input logic [7:0] ofs, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    xfer(1'b0, ofs, 32'h0, d);
    check(d & m, exp);
  endtask

  function automatic logic [31:0] eff(input int n);
    return 32'(n) << `TSL_STAT_EFF_LSB;
  endfunction

  task automatic drive(input int spd, input int tq);
    @(posedge i_core_clk);
    speed <= 16'(spd);
    tref <= 16'(tq);
    repeat (3) @(posedge i_core_clk);
  endtask

  task automatic pin(input logic exp_n, input int exp_t);
    check({31'h0, lim_n}, {31'h0, exp_n});
    check({16'h0, tcmd}, {16'h0, 16'(exp_t)});
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge i_core_clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic servo(input logic on);
    @(posedge i_core_clk);
    servo_on <= on;
    repeat (6) @(posedge i_core_clk);
  endtask

  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rdm(`TSL_OFS_CTRL, 32'h0);
    rdm(`TSL_OFS_SPD_LIM, 32'h2710);
    rdm(`TSL_OFS_GAIN, 32'h258);
    rdm(`TSL_OFS_STATUS, eff(5000), EFF_M);
    pin(1'b1, 0);
    wr(8'h40, 32'hffff);
    rdm(8'h40, 32'h0);
    wr(`TSL_OFS_SPD_LIM, 32'd20000);
    rdm(`TSL_OFS_SPD_LIM, 32'h2710);
    wr(`TSL_OFS_SPD_LIM, 32'd0);
    rdm(`TSL_OFS_SPD_LIM, 32'h0);
    wr(`TSL_OFS_GAIN, 32'd100);
    rdm(`TSL_OFS_GAIN, 32'h96);
    wr(`TSL_OFS_GAIN, 32'd4000);
    rdm(`TSL_OFS_GAIN, 32'hbb8);
    wr(`TSL_OFS_GAIN, 32'd600);
    // internal limit in torque mode, with both interrupt events
    wr(`TSL_OFS_SPD_LIM, 32'd2000);
    wr(`TSL_OFS_CTRL, TQM);
    rdm(`TSL_OFS_STATUS, eff(2000), EFF_M);
    wr(`TSL_OFS_IRQ_STAT, 32'h3);
    wr(`TSL_OFS_IRQ_MASK, 32'h1);
    drive(1999, 100);
    pin(1'b1, 100);
    irq_is(1'b0);
    drive(2000, 100);
    pin(1'b0, 100);
    irq_is(1'b1);
    rdm(`TSL_OFS_IRQ_STAT, 32'h1, 32'h3);
    drive(2010, 100);
    pin(1'b0, 60);
    drive(2100, 100);
    pin(1'b0, -300);
    drive(-2100, 100);
    pin(1'b0, 500);
    wr(`TSL_OFS_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(`TSL_OFS_IRQ_STAT, 32'h1);
    rdm(`TSL_OFS_IRQ_STAT, 32'h0, 32'h3);
    wr(`TSL_OFS_IRQ_MASK, 32'h2);
    drive(1000, 100);
    pin(1'b1, 100);
    irq_is(1'b1);
    rdm(`TSL_OFS_IRQ_STAT, 32'h2, 32'h3);
    wr(`TSL_OFS_SPD_LIM, 32'd9000);
    rdm(`TSL_OFS_STATUS, eff(5000), EFF_M);
    wr(`TSL_OFS_MOTOR_MAX, 32'd10000);
    rdm(`TSL_OFS_STATUS, eff(9000), EFF_M);
    drive(9500, 100);
    wr(`TSL_OFS_CTRL, 32'h0);
    drive(9500, 100);
    pin(1'b1, 100);
    // external limit; each divider pass takes about 31 cycles
    wr(`TSL_OFS_CTRL, TQM | SRC);
    wr(`TSL_OFS_SPD_LIM, 32'd10000);
    for (int i = 0; i < 6; i++) begin
      host.put(16'(vt[i]), i);
      wr(`TSL_OFS_GAIN, 32'(gt[i]));
      repeat (64) @(posedge i_core_clk);
      rdm(`TSL_OFS_STATUS, eff(et[i]), EFF_M);
    end
    host.put(16'sd600, 0);
    wr(`TSL_OFS_GAIN, 32'd150);
    repeat (64) @(posedge i_core_clk);
    rdm(`TSL_OFS_STATUS, eff(10000), EFF_M);
    wr(`TSL_OFS_GAIN, 32'd600);
    wr(`TSL_OFS_SPD_LIM, 32'd2500);
    repeat (64) @(posedge i_core_clk);
    rdm(`TSL_OFS_STATUS, eff(2500), EFF_M);
    drive(2500, 0);
    pin(1'b0, 0);
    // manual offset entry
    wr(`TSL_OFS_CTRL, MAN);
    servo(1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(`TSL_OFS_OFS_CMD, 32'h1);
    end
    wr(`TSL_OFS_OFS_CMD, 32'h2);
    wr(`TSL_OFS_OFS_CMD, 32'h3);
    rdm(`TSL_OFS_OFFSET, 32'h2);
    drive(0, 100);
    pin(1'b1, 102);
    servo(1'b0);
    wr(`TSL_OFS_OFS_CMD, 32'h1);
    rdm(`TSL_OFS_OFFSET, 32'h2);
    servo(1'b1);
    wr(`TSL_OFS_CTRL, 32'h0);
    wr(`TSL_OFS_OFS_CMD, 32'h1);
    rdm(`TSL_OFS_OFFSET, 32'h2);
    wr(`TSL_OFS_CTRL, MAN);
    for (int i = 0; i < 130; i++) begin
      wr(`TSL_OFS_OFS_CMD, 32'h1);
    end
    rdm(`TSL_OFS_OFFSET, 32'h7f);
    for (int i = 0; i < 260; i++) begin
      wr(`TSL_OFS_OFS_CMD, 32'h2);
    end
    rdm(`TSL_OFS_OFFSET, 32'hffffff81);
    conclude();
  end
endmodule // tb_tsl_top
